// file: rtl/card_serial_pkg.sv
package card_serial_pkg;
  // Register addresses, full 20-bit addresses of the serial unit
  localparam logic [19:0] OFS_MODE = 20'hFFFB0;
  localparam logic [19:0] OFS_BRR = 20'hFFFB1;
  localparam logic [19:0] OFS_CTRL = 20'hFFFB2;
  localparam logic [19:0] OFS_TXH = 20'hFFFB3;
  localparam logic [19:0] OFS_FLAGS = 20'hFFFB4;
  localparam logic [19:0] OFS_RXH = 20'hFFFB5;
  localparam logic [19:0] OFS_CMODE = 20'hFFFB6;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_BRR = 8'hFF;
  localparam logic [7:0] RST_TXH = 8'hFF;
  // Mode register fields
  localparam int MODE_GM = 7;
  localparam int MODE_OE = 4;
  localparam int MODE_CKS_HI = 1;
  // Control register fields
  localparam int CTRL_TE = 5;
  localparam int CTRL_RE = 4;
  localparam int CTRL_CLOCK_ENABLE_HI = 1;
  localparam int CTRL_CLOCK_ENABLE_LO = 0;
  // Flag register fields
  localparam int FL_TX_HOLDING_EMPTY_FLAG = 7;
  localparam int FL_RX_HOLDING_FULL_FLAG = 6;
  localparam int FL_OVERRUN_FLAG = 5;
  localparam int FL_ERS = 4;
  localparam int FL_PER = 3;
  localparam int FL_TRANSMIT_END_FLAG = 2;
  // Card mode register fields; bits 7..4 and 1 read as one
  localparam int CM_BIT_ORDER_SELECT = 3;
  localparam int CM_DATA_INVERT_SELECT = 2;
  localparam int CM_CARD_MODE_ENABLE = 0;
  localparam logic [7:0] CM_FIXED_ONES = 8'hF2;
  // Timing: ticks are 1/16 etu; clock out toggles every 13 reference clocks, not scaled
  localparam int TICKS_PER_ETU = 16;
  localparam logic [3:0] HALF_ETU = 4'h8;
  localparam logic [4:0] BITS_DATA = 5'h08;
  localparam logic [4:0] BIT_PAR = 5'h09;
  localparam logic [4:0] ETU_TRANSMIT_END_FLAG_NORM = 5'h0C; // 12.5 etu, plus half
  localparam logic [4:0] ETU_TRANSMIT_END_FLAG_GSM = 5'h0B;  // 11.0 etu
  localparam logic [4:0] ETU_ERR_SAMPLE = 5'h0B; // error bit sampled at 10.5
  localparam logic [4:0] ETU_ERR_START = 5'h0A;  // 10.5 from start
  localparam logic [4:0] ETU_FRAME_END = 5'h0D;  // frame incl. guard 3 etu
  localparam logic [4:0] ETU_RETRY_END = 5'h0E;  // error + 2 etu wait
  localparam logic [6:0] SCK_HALF = 7'h0C;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_RUN = 2'b01
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RUN = 2'b01
  } rx_state_t;
endpackage

// file: rtl/card_serial.sv
`timescale 1ns/100ps
// Behaviour
// - Normal timing: transmit-end flag sets 12.5 etu after start bit begins.
// - Extended timing: transmit-end flag sets 11.0 etu after start bit begins.
// - Normal timing: clock pin is port unless clock enable lo outputs clock.
// - Extended: both low fixed low, enable hi fixed high, enable lo clock.
// - Every frame holds eight data bits then one parity bit.
// - Transmitter leaves at least two etu guard after parity.
// - Receiver with parity error drives line low one etu at 10.5 etu, unless transmit is also enabled.
// - Error signal seen while sending: resend same character after two etu.
// - Only asynchronous framing; no clocked synchronous transfer.
// - Idle line is undriven; pull-up holds it high.
// - Frame: low start bit, data bits zero to seven, parity.
// - Transmitter releases line after the parity bit.
// - Receiver releases line after the error signal.
// - No error: next character; error: resend same character.
// - Transmit and receive enabled together: receiver reads the sent frame back from the line, no error signal.
// - Clock enables 00 disable clock output, 01 enable it.
// - Error flag sets when low error signal sampled during transmission.
// - Bit order select clear LSB first, set MSB first.
// - Data invert flips data bits only, not parity level.
module card_serial
  import card_serial_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Shared data line
  input wire logic i_data_line,
  output logic o_data_out,
  output logic o_data_oe,
  // Card clock pin
  output logic o_sck_out,
  output logic o_sck_oe
);

  function automatic logic [7:0] order_bits(input logic [7:0] v, input logic msb);
    logic [7:0] r;
    r = v;
    if (msb) begin
      for (int k = 0; k < 8; k++) begin
        r[k] = v[7-k];
      end
    end
    return r;
  endfunction

  logic [7:0] mode_q, brr_q, ctrl_q, txh_q, rxh_q;
  logic [7:0] flags_q;
  logic [1:0] cmode_q;
  logic cm_card_mode_enable_q;
  logic [7:0] flags_seen_q;

  logic line_s1_q, line_s2_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
    end else begin
      line_s1_q <= i_data_line;
      line_s2_q <= line_s1_q;
    end
  end

  // Baud tick: 1/16 etu, period scaled by prescale and divisor
  logic [13:0] pre_q;
  logic [7:0] div_q;
  logic [13:0] pre_lim;
  logic pre_hit, tick;
  logic baud_sync;
  assign pre_lim = (mode_q[MODE_CKS_HI:0] == 2'b00) ? 14'h002E :
                   (mode_q[MODE_CKS_HI:0] == 2'b01) ? 14'h00BA :
                   (mode_q[MODE_CKS_HI:0] == 2'b10) ? 14'h02E8 : 14'h0BA0;
  assign pre_hit = (pre_q == pre_lim);
  assign tick = pre_hit && (div_q == brr_q);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= 14'h0000;
      div_q <= 8'h00;
    end else if (baud_sync) begin
      // A transmit frame start restarts the bit clock, so transmit etu counts begin at the start bit
      pre_q <= 14'h0000;
      div_q <= 8'h00;
    end else if (pre_hit) begin
      pre_q <= 14'h0000;
      div_q <= (div_q == brr_q) ? 8'h00 : div_q + 8'h01;
    end else begin
      pre_q <= pre_q + 14'h0001;
    end
  end

  wire card_mode_enable = cm_card_mode_enable_q;
  wire te = ctrl_q[CTRL_TE] && card_mode_enable;
  wire re = ctrl_q[CTRL_RE] && card_mode_enable;
  wire gm = mode_q[MODE_GM];
  wire odd = mode_q[MODE_OE];
  wire bit_order_select = cmode_q[1];
  wire data_invert_select = cmode_q[0];
  wire loop_mode = te && re;

  // Transmitter
  tx_state_t tx_st_q;
  logic [3:0] tx_sub_q;
  logic [4:0] tx_etu_q;
  logic [8:0] tx_sh_q;
  logic tx_drive_q, tx_bit_q, tx_err_q;
  logic tx_end_set, ers_set, tx_load;
  logic [7:0] tx_data;
  assign tx_data = order_bits(data_invert_select ? ~txh_q : txh_q, bit_order_select);
  assign tx_load = te && (tx_st_q == TX_IDLE) && !flags_q[FL_TX_HOLDING_EMPTY_FLAG];
  assign baud_sync = tx_load;
  wire tx_mid = tick && (tx_sub_q == HALF_ETU);
  // Last tick of the first half of a bit: exactly half an etu into it
  wire tx_half = tick && (tx_sub_q == HALF_ETU - 4'h1);
  wire tx_bnd = tick && (tx_sub_q == 4'hF);
  assign tx_end_set = (tx_st_q == TX_RUN) && !tx_err_q &&
    (gm ? (tx_bnd && tx_etu_q == ETU_TRANSMIT_END_FLAG_GSM - 5'h01) :
          (tx_half && tx_etu_q == ETU_TRANSMIT_END_FLAG_NORM));
  assign ers_set = (tx_st_q == TX_RUN) && tx_mid && (tx_etu_q == ETU_ERR_SAMPLE - 5'h01) &&
    !line_s2_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_q <= TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_etu_q <= 5'h00;
      tx_sh_q <= 9'h1FF;
      tx_drive_q <= 1'b0;
      tx_bit_q <= 1'b1;
      tx_err_q <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_drive_q <= 1'b0;
          if (tx_load) begin
            // Start bit now, then data, then parity over line levels
            tx_sh_q <= {odd ^ (^tx_data), tx_data};
            tx_bit_q <= 1'b0;
            tx_drive_q <= 1'b1;
            tx_sub_q <= 4'h0;
            tx_etu_q <= 5'h00;
            tx_err_q <= 1'b0;
            tx_st_q <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
          end
          if (ers_set) begin
            tx_err_q <= 1'b1;
          end
          if (tx_bnd) begin
            tx_etu_q <= tx_etu_q + 5'h01;
            if (tx_etu_q < BIT_PAR) begin
              tx_bit_q <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[8:1]};
              tx_drive_q <= 1'b1;
            end else begin
              tx_drive_q <= 1'b0;
              tx_bit_q <= 1'b1;
            end
            // Guard of 3 etu after parity, or error bit plus 2 etu before resend
            if ((!tx_err_q && tx_etu_q == ETU_FRAME_END - 5'h01) ||
                (tx_err_q && tx_etu_q == ETU_RETRY_END - 5'h01)) begin
              tx_st_q <= TX_IDLE;
              if (tx_err_q && te) begin
                tx_sh_q <= {odd ^ (^tx_data), tx_data};
                tx_bit_q <= 1'b0;
                tx_drive_q <= 1'b1;
                tx_sub_q <= 4'h0;
                tx_etu_q <= 5'h00;
                tx_err_q <= 1'b0;
                tx_st_q <= TX_RUN;
              end
            end
          end
          if (!te) begin
            tx_st_q <= TX_IDLE;
            tx_drive_q <= 1'b0;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Receiver: async start detection only, no shared clock
  rx_state_t rx_st_q;
  logic [3:0] rx_sub_q;
  logic [4:0] rx_etu_q;
  logic [8:0] rx_sh_q;
  logic rx_err_drive_q, rx_perr_q;
  logic rx_done, rx_bad;
  wire rx_line = line_s2_q;
  wire rx_mid = tick && (rx_sub_q == HALF_ETU);
  wire rx_bnd = tick && (rx_sub_q == 4'hF);
  // Data bits sit in 8:1 while the parity bit is still on the line
  assign rx_bad = (^{rx_line, rx_sh_q[8:1]}) ^ odd; // parity over line levels
  assign rx_done = (rx_st_q == RX_RUN) && rx_mid && (rx_etu_q == BIT_PAR);
  wire [7:0] rx_word = order_bits(data_invert_select ? ~rx_sh_q[8:1] : rx_sh_q[8:1], bit_order_select);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_q <= RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_etu_q <= 5'h00;
      rx_sh_q <= 9'h000;
      rx_err_drive_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          rx_err_drive_q <= 1'b0;
          if (re && !rx_line) begin
            rx_sub_q <= 4'h0;
            rx_etu_q <= 5'h00;
            rx_perr_q <= 1'b0;
            rx_st_q <= RX_RUN;
          end
        end
        RX_RUN: begin
          if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
          end
          if (rx_mid && rx_etu_q >= 5'h01 && rx_etu_q <= BIT_PAR) begin
            rx_sh_q <= {rx_line, rx_sh_q[8:1]};
          end
          if (rx_done) begin
            rx_perr_q <= (^{rx_line, rx_sh_q[8:1]}) ^ odd;
          end
          // Error signal spans 10.5 to 11.5 etu from start
          if (rx_mid && rx_etu_q == ETU_ERR_START) begin
            rx_err_drive_q <= rx_perr_q && !loop_mode;
          end
          if (rx_mid && rx_etu_q == ETU_ERR_START + 5'h01) begin
            rx_err_drive_q <= 1'b0;
          end
          if (rx_bnd) begin
            rx_etu_q <= rx_etu_q + 5'h01;
            if (rx_etu_q == ETU_FRAME_END - 5'h02) begin
              rx_st_q <= RX_IDLE;
            end
          end
          if (!re) begin
            rx_st_q <= RX_IDLE;
            rx_err_drive_q <= 1'b0;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Data line: open-drain style, drive only low or while transmitting
  assign o_data_oe = tx_drive_q || rx_err_drive_q;
  assign o_data_out = rx_err_drive_q ? 1'b0 : tx_bit_q;

  // Card clock divider and pin control
  logic [6:0] sck_cnt_q;
  logic sck_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sck_cnt_q <= 7'h00;
      sck_q <= 1'b0;
    end else if (sck_cnt_q == SCK_HALF) begin
      sck_cnt_q <= 7'h00;
      sck_q <= ~sck_q;
    end else begin
      sck_cnt_q <= sck_cnt_q + 7'h01;
    end
  end
  wire clock_enable_lo = ctrl_q[CTRL_CLOCK_ENABLE_LO];
  wire clock_enable_hi = ctrl_q[CTRL_CLOCK_ENABLE_HI];
  assign o_sck_oe = card_mode_enable && (clock_enable_lo || gm);
  assign o_sck_out = clock_enable_lo ? sck_q : (gm && clock_enable_hi);

  // Register writes; flags clear by writing 0 after reading them set, the transmit-end flag via bit 7
  wire wr_flags = i_wr && (i_addr == OFS_FLAGS);
  wire [7:0] clr = wr_flags ? (flags_seen_q & ~i_wdata) : 8'h00;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= RST_ZERO;
      ctrl_q <= RST_ZERO;
      brr_q <= RST_BRR;
      txh_q <= RST_TXH;
      rxh_q <= RST_ZERO;
      cmode_q <= 2'b00;
      cm_card_mode_enable_q <= 1'b0;
      flags_q <= 8'h84;
      flags_seen_q <= 8'h00;
    end else begin
      if (i_wr && i_addr == OFS_MODE) mode_q <= i_wdata;
      if (i_wr && i_addr == OFS_BRR) brr_q <= i_wdata;
      if (i_wr && i_addr == OFS_CTRL) ctrl_q <= i_wdata;
      if (i_wr && i_addr == OFS_TXH) txh_q <= i_wdata;
      if (i_wr && i_addr == OFS_CMODE) begin
        cmode_q <= {i_wdata[CM_BIT_ORDER_SELECT], i_wdata[CM_DATA_INVERT_SELECT]};
        cm_card_mode_enable_q <= i_wdata[CM_CARD_MODE_ENABLE];
      end
      if (i_rd && i_addr == OFS_FLAGS) flags_seen_q <= flags_q;
      if (rx_done) rxh_q <= rx_word;
      // Set wins over a clear in the same cycle
      flags_q[FL_TX_HOLDING_EMPTY_FLAG] <= tx_load ? 1'b0 : flags_q[FL_TX_HOLDING_EMPTY_FLAG] & ~clr[FL_TX_HOLDING_EMPTY_FLAG];
      if (clr[FL_TX_HOLDING_EMPTY_FLAG]) flags_q[FL_TX_HOLDING_EMPTY_FLAG] <= 1'b0;
      if (tx_load) flags_q[FL_TX_HOLDING_EMPTY_FLAG] <= 1'b1;
      flags_q[FL_ERS] <= ers_set | (flags_q[FL_ERS] & ~clr[FL_ERS]);
      flags_q[FL_TRANSMIT_END_FLAG] <= tx_end_set | (!te && !flags_q[FL_ERS]) |
        (flags_q[FL_TRANSMIT_END_FLAG] & ~clr[FL_TX_HOLDING_EMPTY_FLAG]);
      flags_q[FL_RX_HOLDING_FULL_FLAG] <= (rx_done && !rx_bad) | (flags_q[FL_RX_HOLDING_FULL_FLAG] & ~clr[FL_RX_HOLDING_FULL_FLAG]);
      flags_q[FL_PER] <= (rx_done && rx_bad) | (flags_q[FL_PER] & ~clr[FL_PER]);
      flags_q[FL_OVERRUN_FLAG] <= (rx_done && flags_q[FL_RX_HOLDING_FULL_FLAG]) | (flags_q[FL_OVERRUN_FLAG] & ~clr[FL_OVERRUN_FLAG]);
      flags_q[1:0] <= 2'b00;
    end
  end

  // Read data one cycle after the strobe
  logic [7:0] rd_mux;
  assign rd_mux = (i_addr == OFS_MODE) ? mode_q :
                  (i_addr == OFS_BRR) ? brr_q :
                  (i_addr == OFS_CTRL) ? ctrl_q :
                  (i_addr == OFS_TXH) ? txh_q :
                  (i_addr == OFS_FLAGS) ? flags_q :
                  (i_addr == OFS_RXH) ? rxh_q :
                  (i_addr == OFS_CMODE) ? (CM_FIXED_ONES |
                    {4'h0, cmode_q, 1'b0, cm_card_mode_enable_q}) : 8'h00;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

endmodule

// file: verif/card_serial_sva.sv
`timescale 1ns/100ps
module card_serial_sva
  import card_serial_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_data_line,
  input wire logic o_data_out,
  input wire logic o_data_oe,
  input wire logic o_sck_out,
  input wire logic o_sck_oe
);
  logic ext_q, card_en_q;
  logic [1:0] clk_en_q, psc_q;
  logic [7:0] div_q;
  logic [31:0] etu, on_q, off_q;
  // Bit time mirrored from the register writes
  assign etu = 32'h10 * (32'(div_q) + 32'h1) * ((psc_q == 2'h0) ? 32'h2F :
    (psc_q == 2'h1) ? 32'hBB : (psc_q == 2'h2) ? 32'h2E9 : 32'hBA1);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_q <= 1'b0;
      card_en_q <= 1'b0;
      clk_en_q <= 2'h0;
      psc_q <= 2'h0;
      div_q <= 8'hFF;
    end else if (i_wr && i_addr == OFS_MODE) begin
      ext_q <= i_wdata[7];
      psc_q <= i_wdata[1:0];
    end else if (i_wr && i_addr == OFS_MODE + 20'h1) begin
      div_q <= i_wdata;
    end else if (i_wr && i_addr == OFS_CTRL) begin
      clk_en_q <= i_wdata[1:0];
    end else if (i_wr && i_addr == OFS_CMODE) begin
      card_en_q <= i_wdata[0];
    end
  end
  // Length of the current drive and of the current release
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_q <= 32'h0;
      off_q <= 32'hFFFFFF;
    end else begin
      on_q <= o_data_oe ? on_q + 32'h1 : 32'h0;
      off_q <= o_data_oe ? 32'h0 : off_q + 32'(off_q < 32'hFFFFFF);
    end
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  start_low_a: assert property ($rose(o_data_oe) |-> !o_data_out)
    else $error("frame start not low");
  drive_len_a: assert property (o_data_oe |-> on_q < 32'hA * etu + 32'h2)
    else $error("line driven too long");
  guard_gap_a: assert property ($rose(o_data_oe) |-> off_q >= 32'h2 * etu)
    else $error("guard time too short");
  idle_line_a: assert property (!card_en_q |-> !o_data_oe)
    else $error("line driven while card mode off");
  sck_port_a: assert property ((!ext_q && !clk_en_q[0]) [*3] |-> !o_sck_oe)
    else $error("clock pin driven while off");
  sck_low_a: assert property (
    (ext_q && clk_en_q == 2'h0) [*3] |-> o_sck_oe && !o_sck_out)
    else $error("clock pin not fixed low");
  sck_high_a: assert property (
    (ext_q && clk_en_q == 2'h2) [*3] |-> o_sck_oe && o_sck_out)
    else $error("clock pin not fixed high");
  sck_clock_a: assert property (clk_en_q[0] [*3] |-> o_sck_oe)
    else $error("clock pin not driven");
  cover property ($rose(o_data_oe));
  cover property ($rose(o_data_oe) && off_q < 32'h5 * etu);
  cover property (ext_q && clk_en_q == 2'h2 && o_sck_out);
endmodule

bind card_serial card_serial_sva chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data_line(i_data_line),
  .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_sck_out(o_sck_out), .o_sck_oe(o_sck_oe)
);

// file: verif/card_model.sv
`timescale 1ns/100ps
module card_model #(parameter int ETU = 752) (
  input wire logic i_clk,
  input wire logic i_line,
  input wire logic i_err_req,
  output logic o_pull_low,
  output logic [7:0] o_raw,
  output logic o_par,
  output int o_frames
);
  initial begin : listen
    int b;
    o_pull_low = 1'b0;
    o_raw = 8'h00;
    o_par = 1'b0;
    o_frames = 0;
    forever begin
      @(negedge i_line);
      repeat (ETU / 2) @(posedge i_clk);
      for (b = 0; b < 9; b++) begin
        repeat (ETU) @(posedge i_clk);
        if (b < 8)
          o_raw[b] = i_line;
        else
          o_par = i_line;
      end
      o_frames++;
      if (i_err_req) begin
        repeat (ETU) @(posedge i_clk);
        o_pull_low <= 1'b1;
        repeat (ETU) @(posedge i_clk);
        o_pull_low <= 1'b0;
      end
    end
  end
endmodule

// file: verif/card_serial_tb_top.sv
`timescale 1ns/100ps
module card_serial_tb_top;
  import card_serial_pkg::*;
  localparam int ETU = 752;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [19:0] addr = 20'h00000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic err_req = 1'b0;
  logic [7:0] rdata, raw, got;
  logic data_out, data_oe, sck_out, sck_oe, card_low, par;
  wire data_line = !((data_oe && !data_out) || card_low);
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int frames;
  always #5 ref_clk = ~ref_clk;
  card_serial uut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_data_line(data_line), .o_data_out(data_out),
    .o_data_oe(data_oe), .o_sck_out(sck_out), .o_sck_oe(sck_oe)
  );
  card_model #(.ETU(ETU)) card (
    .i_clk(ref_clk), .i_line(data_line), .i_err_req(err_req), .o_pull_low(card_low),
    .o_raw(raw), .o_par(par), .o_frames(frames)
  );
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [19:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Waits for the end flag of the last frame, starts a frame, then probes the end flag
  // either side of its due time, if half_etus is not zero
  task automatic send(input logic [7:0] d, input int half_etus);
    int n;
    got = 8'h00;
    for (n = 0; n < 4 * ETU && got[FL_TRANSMIT_END_FLAG] !== 1'b1; n++)
      rd_reg(OFS_FLAGS);
    wr_reg(OFS_TXH, d);
    rd_reg(OFS_FLAGS);
    wr_reg(OFS_FLAGS, 8'h7B);
    for (n = 0; n < 4 * ETU && data_oe !== 1'b1; n++)
      @(negedge ref_clk);
    if (half_etus > 0) begin
      repeat (half_etus * ETU / 2 - 20) @(posedge ref_clk);
      rd_reg(OFS_FLAGS);
      chk("end_early", 8'h00, got & 8'h04);
      repeat (36) @(posedge ref_clk);
      rd_reg(OFS_FLAGS);
      chk("end_flag", 8'h04, got & 8'h04);
    end
  endtask
  task automatic frame_chk(input int n, input logic [7:0] exp, input logic p);
    int k;
    for (k = 0; k < 20 * ETU && frames < n; k++)
      @(posedge ref_clk);
    chk("card_data", exp, raw);
    chk("card_parity", {7'h00, p}, {7'h00, par});
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      fails = fails + 1;
      wrap_up();
    end
  end
  initial begin : main
    logic [7:0] rv [7];
    logic [5:0] ck [5];
    logic lvl;
    rv = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h84, 8'h00, 8'hF2};
    // Mode, clock enables, pin enable, level, level checked
    ck = '{6'h00, 6'h25, 6'h37, 6'h2C, 6'h0C};
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_reg(OFS_MODE + 20'(i));
      chk("reset_value", rv[i], got);
    end
    rd_reg(OFS_MODE + 20'h7);
    chk("unmapped", 8'h00, got);
    wr_reg(OFS_RXH, 8'h55);
    rd_reg(OFS_RXH);
    chk("read_only", 8'h00, got);
    wr_reg(OFS_MODE + 20'h1, 8'h00);
    wr_reg(OFS_CMODE, 8'h01);
    rd_reg(OFS_CMODE);
    chk("card_mode", 8'hF3, got);
    @(posedge ref_clk);
    #1;
    chk("rdata_idle", 8'h00, rdata);
    $display("Test registers done");
    foreach (ck[i]) begin
      wr_reg(OFS_CTRL, {6'h00, ck[i][4:3]});
      wr_reg(OFS_MODE, {ck[i][5], 7'h28});
      repeat (4) @(posedge ref_clk);
      #1;
      chk("sck_enable", {7'h00, ck[i][2]}, {7'h00, sck_oe});
      if (ck[i][0])
        chk("sck_level", {7'h00, ck[i][1]}, {7'h00, sck_out});
      if (ck[i][3]) begin
        lvl = sck_out;
        repeat (SCK_HALF + 7'h01) @(posedge ref_clk);
        #1;
        chk("sck_toggle", {7'h00, ~lvl}, {7'h00, sck_out});
      end
    end
    $display("Test clock pin done");
    wr_reg(OFS_CTRL, 8'h21);
    send(8'h5A, 25);
    frame_chk(1, 8'h5A, 1'b0);
    wr_reg(OFS_MODE, 8'hA8);
    send(8'hC3, 22);
    frame_chk(2, 8'hC3, 1'b0);
    $display("Test end timing done");
    wr_reg(OFS_MODE, 8'h28);
    err_req <= 1'b1;
    send(8'h96, 0);
    frame_chk(3, 8'h96, 1'b0);
    err_req <= 1'b0;
    frame_chk(4, 8'h96, 1'b0);
    repeat (4 * ETU) @(posedge ref_clk);
    rd_reg(OFS_FLAGS);
    chk("error_flag", 8'h10, got & 8'h10);
    wr_reg(OFS_FLAGS, 8'hEF);
    rd_reg(OFS_FLAGS);
    chk("error_clear", 8'h00, got & 8'h10);
    $display("Test retry done");
    wr_reg(OFS_CTRL, 8'h01);
    wr_reg(OFS_CMODE, 8'h0D);
    wr_reg(OFS_MODE, 8'h38);
    wr_reg(OFS_CTRL, 8'h31);
    send(8'h3F, 0);
    frame_chk(5, 8'h03, 1'b1);
    repeat (4 * ETU) @(posedge ref_clk);
    rd_reg(OFS_RXH);
    chk("loop_data", 8'h3F, got);
    rd_reg(OFS_FLAGS);
    chk("loop_full", 8'h40, got & 8'h40);
    $display("Test loopback done");
    wrap_up();
  end
endmodule
